// file: ptbi_params.svh
`ifndef PTBI_PARAMS_SVH
`define PTBI_PARAMS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define PTBI_ADDR_WIDTH        12
`define PTBI_CTRL_OFFSET       12'h039
`define PTBI_STATUS_OFFSET     12'h03a
`define PTBI_MASK_OFFSET       12'h03b

// ****************************************************************
// field positions
// ****************************************************************
`define PTBI_CTRL_EN_BIT       3
`define PTBI_CTRL_SEL_MSB      2
`define PTBI_CTRL_SEL_LSB      0
`define PTBI_EVT_TICK_BIT      0
`define PTBI_EVT_STOP_BIT      1
`define PTBI_EVT_WIDTH         2

// ****************************************************************
// reset values
// ****************************************************************
`define PTBI_CTRL_EN_RESET     1'h0
`define PTBI_CTRL_SEL_RESET    3'h0
`define PTBI_STATUS_RESET      2'h0
`define PTBI_MASK_RESET        2'h0
`define PTBI_RDATA_RESET       8'h00

// ****************************************************************
// divider chain: widths and tap exponents per select code
// ****************************************************************
`define PTBI_GEAR_WIDTH        22
`define PTBI_LF_WIDTH          15
`define PTBI_GEAR_EXP_0        22
`define PTBI_GEAR_EXP_1        20
`define PTBI_GEAR_EXP_2        15
`define PTBI_GEAR_EXP_3        13
`define PTBI_GEAR_EXP_4        12
`define PTBI_GEAR_EXP_5        11
`define PTBI_GEAR_EXP_6        10
`define PTBI_GEAR_EXP_7        8
`define PTBI_LF_EXP_0          15
`define PTBI_LF_EXP_1          13
`define PTBI_LF_EXP_2          8
`define PTBI_LF_EXP_3          6
`define PTBI_LF_EXP_4          5
`define PTBI_LF_EXP_5          4
`define PTBI_LF_EXP_6          3
`define PTBI_LF_EXP_7          3
`define PTBI_LF_RESERVED_CODE  3'h7
`define PTBI_SLOW_MAX_CODE     3'h1

`endif

// file: ptbi_pkg.sv
package ptbi_pkg;

  // ****************************************************************
  // operating modes, gray coded along normal-idle-slow-sleep-stop
  // ****************************************************************
  typedef enum logic [2:0] {
    PTBI_MODE_NORMAL = 3'h0,
    PTBI_MODE_IDLE   = 3'h1,
    PTBI_MODE_SLOW   = 3'h3,
    PTBI_MODE_SLEEP  = 3'h2,
    PTBI_MODE_STOP   = 3'h6
  } ptbi_mode_t;

  // ****************************************************************
  // time base source
  // ****************************************************************
  typedef enum logic {
    PTBI_SRC_GEAR = 1'h0,
    PTBI_SRC_LOWF = 1'h1
  } ptbi_src_t;

endpackage

// file: ptbi_divider.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// free-running binary divider chain
// ****************************************************************
module ptbi_divider #(
  parameter int WIDTH = 22
) (
  input  wire logic             clock_i,
  input  wire logic             reset_n_i,
  input  wire logic             advance_i,
  output logic      [WIDTH-1:0] count_o
);

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      count_o <= '0;
    end else if (advance_i) begin
      count_o <= WIDTH'(count_o + 1'b1);
    end
  end

endmodule // ptbi_divider

`default_nettype wire

// file: ptbi_sync_edge.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// two-stage synchroniser with rising edge pulse
// ****************************************************************
module ptbi_sync_edge (
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  input  wire logic async_i,
  output logic      level_o,
  output logic      rise_o
);

  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign level_o = stage2;
  assign rise_o  = stage2 & ~stage3;

endmodule // ptbi_sync_edge

`default_nettype wire

// file: ptbi_time_base.sv
// Behaviour
// - control holds enable at bit 3, rate select bits 2..0, both reset zero.
// - control bits 7..4 read zero and ignore writes.
// - enabled, tick at each falling edge of selected tap; disabled, no tick.
// - divider chains run always, enabling never restarts them.
// - first tick after enable comes at the next falling edge of the tap.
// - gear base codes 0..7 divide by 2^22,20,15,13,12,11,10,8.
// - low-freq codes 0..6 divide 2^15,13,8,6,5,4,3; 7 reserved; slow allows 0,1.
// - entering stop clears enable and keeps the rate select.
// - low-freq ticks jitter because that clock is resynchronised.
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "ptbi_params.svh"

module ptbi_time_base (
  input  wire logic                                clock_i,
  input  wire logic                                reset_n_i,
  input  wire logic       [`PTBI_ADDR_WIDTH-1:0]   addr_i,
  input  wire logic       [7:0]                    wdata_i,
  input  wire logic                                write_i,
  input  wire logic                                read_i,
  output logic            [7:0]                    rdata_o,
  input  wire ptbi_pkg::ptbi_mode_t                op_mode_i,
  input  wire logic                                low_freq_base_select_i,
  input  wire logic                                low_frequency_clock_i,
  output logic                                     tick_interrupt_o,
  output logic                                     irq_o
);

  // ****************************************************************
  // tap tables
  // ****************************************************************
  localparam int GEAR_EXP [8] = '{`PTBI_GEAR_EXP_0, `PTBI_GEAR_EXP_1,
                                  `PTBI_GEAR_EXP_2, `PTBI_GEAR_EXP_3,
                                  `PTBI_GEAR_EXP_4, `PTBI_GEAR_EXP_5,
                                  `PTBI_GEAR_EXP_6, `PTBI_GEAR_EXP_7};
  localparam int LF_EXP   [8] = '{`PTBI_LF_EXP_0, `PTBI_LF_EXP_1,
                                  `PTBI_LF_EXP_2, `PTBI_LF_EXP_3,
                                  `PTBI_LF_EXP_4, `PTBI_LF_EXP_5,
                                  `PTBI_LF_EXP_6, `PTBI_LF_EXP_7};

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic                         tick_irq_enable;
  logic [2:0]                   tick_rate_select;
  logic [`PTBI_EVT_WIDTH-1:0]   status;
  logic [`PTBI_EVT_WIDTH-1:0]   mask;
  ptbi_pkg::ptbi_mode_t         mode_prev;

  logic                         next_tick_irq_enable;
  logic [2:0]                   next_tick_rate_select;
  logic [`PTBI_EVT_WIDTH-1:0]   next_status;
  logic [`PTBI_EVT_WIDTH-1:0]   next_mask;
  logic [7:0]                   next_rdata;

  wire                          sel_ctrl;
  wire                          sel_status;
  wire                          sel_mask;
  wire                          wr_ctrl;
  wire                          wr_status;
  wire                          wr_mask;
  wire  [7:0]                   ctrl_view;
  wire  [7:0]                   status_view;
  wire  [7:0]                   mask_view;

  wire                          stop_entry;
  wire                          lf_mode;
  ptbi_pkg::ptbi_src_t          source;
  wire                          code_valid;

  logic                         lf_rise;
  logic [`PTBI_GEAR_WIDTH-1:0]  gear_count;
  logic [`PTBI_LF_WIDTH-1:0]    lf_count;
  wire  [7:0]                   gear_tap;
  wire  [7:0]                   lf_tap;
  logic [7:0]                   gear_tap_q;
  logic [7:0]                   lf_tap_q;
  wire  [7:0]                   gear_fall;
  wire  [7:0]                   lf_fall;
  wire                          selected_fall;
  wire                          tick_event;
  wire                          stop_event;
  wire  [`PTBI_EVT_WIDTH-1:0]   events;

  // ****************************************************************
  // named decode and selection terms
  // ****************************************************************
  wire                          rd_ctrl;
  wire                          rd_status;
  wire                          rd_mask;
  wire                          wr_enable_bit;
  wire  [2:0]                   wr_rate_field;
  wire  [`PTBI_EVT_WIDTH-1:0]   clear_bits;
  wire                          mode_is_stop;
  wire                          mode_was_stop;
  wire                          slow_code_ok;
  wire                          lf_code_ok;
  wire                          gear_sel_fall;
  wire                          lf_sel_fall;
  wire                          enabled_fall;
  wire  [`PTBI_EVT_WIDTH-1:0]   pending;

  // ****************************************************************
  // register decode
  // ****************************************************************
  assign sel_ctrl   = (addr_i == `PTBI_CTRL_OFFSET);
  assign sel_status = (addr_i == `PTBI_STATUS_OFFSET);
  assign sel_mask   = (addr_i == `PTBI_MASK_OFFSET);
  assign wr_ctrl    = write_i & sel_ctrl;
  assign wr_status  = write_i & sel_status;
  assign wr_mask    = write_i & sel_mask;
  assign rd_ctrl    = read_i & sel_ctrl;
  assign rd_status  = read_i & sel_status;
  assign rd_mask    = read_i & sel_mask;

  // upper control bits are tied to zero on read
  assign ctrl_view   = {4'h0, tick_irq_enable, tick_rate_select};
  assign status_view = {6'h00, status};
  assign mask_view   = {6'h00, mask};

  // unmapped reads and idle cycles return zero
  assign next_rdata = rd_ctrl   ? ctrl_view :
                      rd_status ? status_view :
                      rd_mask   ? mask_view :
                                  `PTBI_RDATA_RESET;

  // ****************************************************************
  // operating mode tracking
  // ****************************************************************
  // stop entry is the first cycle in which the mode reads stop
  assign mode_is_stop  = (op_mode_i == ptbi_pkg::PTBI_MODE_STOP);
  assign mode_was_stop = (mode_prev == ptbi_pkg::PTBI_MODE_STOP);
  assign stop_entry    = mode_is_stop & ~mode_was_stop;
  assign lf_mode    = (op_mode_i == ptbi_pkg::PTBI_MODE_SLOW) ||
                      (op_mode_i == ptbi_pkg::PTBI_MODE_SLEEP);

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      mode_prev <= ptbi_pkg::PTBI_MODE_NORMAL;
    end else begin
      mode_prev <= op_mode_i;
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  assign wr_enable_bit = wdata_i[`PTBI_CTRL_EN_BIT];
  assign wr_rate_field = wdata_i[`PTBI_CTRL_SEL_MSB:`PTBI_CTRL_SEL_LSB];

  // stop entry overrides a write of the enable in the same cycle
  assign next_tick_irq_enable = stop_entry ? 1'b0 :
                                wr_ctrl    ? wr_enable_bit :
                                             tick_irq_enable;
  // rate select follows software only; stop leaves it untouched
  assign next_tick_rate_select = wr_ctrl ?
                                 wr_rate_field :
                                 tick_rate_select;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      tick_irq_enable  <= `PTBI_CTRL_EN_RESET;
      tick_rate_select <= `PTBI_CTRL_SEL_RESET;
    end else begin
      tick_irq_enable  <= next_tick_irq_enable;
      tick_rate_select <= next_tick_rate_select;
    end
  end

  // ****************************************************************
  // low-frequency clock resynchronisation
  // ****************************************************************
  // edge position shifts by up to one system cycle per period
  ptbi_sync_edge u_lf_sync (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .async_i   (low_frequency_clock_i),
    .level_o   (),
    .rise_o    (lf_rise)
  );

  // ****************************************************************
  // divider chains
  // ****************************************************************
  // both chains free-run regardless of the enable
  ptbi_divider #(
    .WIDTH (`PTBI_GEAR_WIDTH)
  ) u_gear_div (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .advance_i (1'b1),
    .count_o   (gear_count)
  );

  ptbi_divider #(
    .WIDTH (`PTBI_LF_WIDTH)
  ) u_lf_div (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .advance_i (lf_rise),
    .count_o   (lf_count)
  );

  // ****************************************************************
  // tap selection and falling edge detect per select code
  // ****************************************************************
  // one tap and one falling edge detector per chain and select code
  genvar code;
  generate
    for (code = 0; code < 8; code++) begin : g_tap
      assign gear_tap[code]  = gear_count[GEAR_EXP[code]-1];
      assign lf_tap[code]    = lf_count[LF_EXP[code]-1];
      assign gear_fall[code] = gear_tap_q[code] & ~gear_tap[code];
      assign lf_fall[code]   = lf_tap_q[code] & ~lf_tap[code];
    end
  endgenerate

  // previous taps reset low, matching the cleared counters
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      gear_tap_q <= 8'h00;
      lf_tap_q   <= 8'h00;
    end else begin
      gear_tap_q <= gear_tap;
      lf_tap_q   <= lf_tap;
    end
  end

  // slow and sleep run from the low-frequency clock
  assign source = (lf_mode || low_freq_base_select_i) ?
                  ptbi_pkg::PTBI_SRC_LOWF : ptbi_pkg::PTBI_SRC_GEAR;

  // reserved codes never tick
  assign slow_code_ok = (tick_rate_select <= `PTBI_SLOW_MAX_CODE);
  assign lf_code_ok   = (tick_rate_select != `PTBI_LF_RESERVED_CODE);
  assign code_valid   = lf_mode                ? slow_code_ok :
                        low_freq_base_select_i ? lf_code_ok :
                                                 1'b1;

  assign gear_sel_fall = gear_fall[tick_rate_select];
  assign lf_sel_fall   = lf_fall[tick_rate_select];
  assign selected_fall = (source == ptbi_pkg::PTBI_SRC_LOWF) ?
                         lf_sel_fall : gear_sel_fall;

  // a tap that is mid-period at enable gives a short first interval
  assign enabled_fall = tick_irq_enable & selected_fall;
  assign tick_event   = enabled_fall & code_valid;
  assign stop_event = stop_entry & tick_irq_enable;

  // ****************************************************************
  // tick output
  // ****************************************************************
  // registered so the request is a clean single-cycle pulse
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      tick_interrupt_o <= 1'b0;
    end else begin
      tick_interrupt_o <= tick_event;
    end
  end

  // ****************************************************************
  // sticky status, mask and interrupt line
  // ****************************************************************
  // the stop bit records an enable that stop entry cleared
  assign events[`PTBI_EVT_TICK_BIT] = tick_event;
  assign events[`PTBI_EVT_STOP_BIT] = stop_event;

  // a new event beats a write-one-to-clear in the same cycle
  assign clear_bits  = wr_status ? wdata_i[`PTBI_EVT_WIDTH-1:0] : `PTBI_STATUS_RESET;
  assign next_status = (status & ~clear_bits) | events;
  assign next_mask   = wr_mask ? wdata_i[`PTBI_EVT_WIDTH-1:0] : mask;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      status <= `PTBI_STATUS_RESET;
      mask   <= `PTBI_MASK_RESET;
    end else begin
      status <= next_status;
      mask   <= next_mask;
    end
  end

  assign pending = status & mask;
  assign irq_o   = |pending;

  // ****************************************************************
  // read data
  // ****************************************************************
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rdata_o <= `PTBI_RDATA_RESET;
    end else begin
      rdata_o <= next_rdata;
    end
  end

endmodule // ptbi_time_base

`default_nettype wire

// file: ptbi_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "ptbi_params.svh"
// ****************
// port checks
// ****************
module ptbi_properties (
  input wire logic                 clock_i,
  input wire logic                 reset_n_i,
  input wire logic [11:0]          addr_i,
  input wire logic [7:0]           wdata_i,
  input wire logic                 write_i,
  input wire logic                 read_i,
  input wire logic [7:0]           rdata_o,
  input wire ptbi_pkg::ptbi_mode_t op_mode_i,
  input wire logic                 low_freq_base_select_i,
  input wire logic                 low_frequency_clock_i,
  input wire logic                 tick_interrupt_o,
  input wire logic                 irq_o
);
  logic       en_q;
  logic [2:0] sel_q;
  logic [1:0] mask_q;
  logic [2:0] mode_q;
  logic       run_ok;
  int         gap;
  wire logic ctrl_wr = write_i && addr_i == `PTBI_CTRL_OFFSET;
  wire logic in_stop = op_mode_i == ptbi_pkg::PTBI_MODE_STOP;
  wire logic stop_in = in_stop && mode_q != 3'h6;
  wire logic slowish = op_mode_i inside {ptbi_pkg::PTBI_MODE_SLOW, ptbi_pkg::PTBI_MODE_SLEEP};
  wire logic gear7 = !low_freq_base_select_i && sel_q == 3'h7 && op_mode_i == 3'h0;
  wire logic resv = (low_freq_base_select_i && sel_q == 3'h7) || (slowish && sel_q > 3'h1);
  wire logic mapped = addr_i inside {`PTBI_CTRL_OFFSET, `PTBI_STATUS_OFFSET, `PTBI_MASK_OFFSET};
  // shadow of the control and mask registers
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      en_q <= 1'b0;
      sel_q <= 3'h0;
      mask_q <= 2'h0;
      mode_q <= 3'h0;
      run_ok <= 1'b0;
      gap <= 0;
    end else begin
      mode_q <= op_mode_i;
      gap <= tick_interrupt_o ? 0 : gap + 1;
      run_ok <= (ctrl_wr || !gear7) ? 1'b0 : (run_ok || tick_interrupt_o);
      if (ctrl_wr)
        sel_q <= wdata_i[2:0];
      if (stop_in)
        en_q <= 1'b0;
      else if (ctrl_wr)
        en_q <= wdata_i[3];
      if (write_i && addr_i == `PTBI_MASK_OFFSET)
        mask_q <= wdata_i[1:0];
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  property p_ctrl_read;
    read_i && addr_i == `PTBI_CTRL_OFFSET |=> rdata_o == {4'h0, $past(en_q), $past(sel_q)};
  endproperty
  property p_unmapped;
    read_i && !mapped |=> rdata_o == 8'h00;
  endproperty
  property p_pulse;
    tick_interrupt_o |=> !tick_interrupt_o;
  endproperty
  property p_no_tick_off;
    tick_interrupt_o |-> $past(en_q) || $past(en_q, 2);
  endproperty
  property p_gear_period;
    tick_interrupt_o && run_ok |-> gap == 255;
  endproperty
  property p_reserved;
    (resv && !ctrl_wr) [*4] |-> !tick_interrupt_o;
  endproperty
  property p_stop;
    (in_stop && !write_i) [*4] |-> !tick_interrupt_o;
  endproperty
  property p_irq;
    tick_interrupt_o && mask_q[0] |-> irq_o;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control read back wrong");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_pulse: assert property (p_pulse)
    else $error("tick longer than one cycle");
  a_no_tick_off: assert property (p_no_tick_off)
    else $error("tick while disabled");
  a_gear_period: assert property (p_gear_period)
    else $error("gear tick spacing wrong");
  a_reserved: assert property (p_reserved)
    else $error("tick on reserved code");
  a_stop: assert property (p_stop)
    else $error("tick in stop");
  a_irq: assert property (p_irq)
    else $error("irq low with unmasked tick");
  c_tick: cover property (tick_interrupt_o);
  c_irq: cover property (irq_o);
  c_stop: cover property (stop_in);
endmodule // ptbi_properties

bind ptbi_time_base ptbi_properties ptbi_properties_i (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .op_mode_i(op_mode_i),
  .low_freq_base_select_i(low_freq_base_select_i),
  .low_frequency_clock_i(low_frequency_clock_i),
  .tick_interrupt_o(tick_interrupt_o), .irq_o(irq_o));
`default_nettype wire

// file: ptbi_intc_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************
// interrupt controller
// ****************
module ptbi_intc_model (
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  input  wire logic tick_i,
  output var  int   count_o,
  output var  int   stamp_o,
  output var  int   cycle_o
);
  // one request taken per pulse, stamped with its cycle
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      count_o <= 0;
      stamp_o <= 0;
      cycle_o <= 0;
    end else begin
      cycle_o <= cycle_o + 1;
      if (tick_i) begin
        count_o <= count_o + 1;
        stamp_o <= cycle_o;
      end
    end
  end
endmodule // ptbi_intc_model
`default_nettype wire

// file: tb_ptbi_time_base.sv
`timescale 1ns/100ps
`default_nettype none
`include "ptbi_params.svh"
// ****************
// bench
// ****************
module tb_ptbi_time_base;
  logic                 clock_i = 1'b0;
  logic                 reset_n_i = 1'b0;
  logic [11:0]          addr = 12'h000;
  logic [7:0]           wdata = 8'h00;
  logic                 wr_s = 1'b0;
  logic                 rd_s = 1'b0;
  logic                 lf_sel = 1'b0;
  logic                 lf_clk = 1'b0;
  ptbi_pkg::ptbi_mode_t mode = ptbi_pkg::PTBI_MODE_NORMAL;
  wire logic [7:0]      rdata;
  wire logic            tick;
  wire logic            irq;
  int count, stamp, cyc, t0, n, v;
  int err_count = 0;
  int n_compared = 0;
  int seed = 72;
  int m_ctrl = 0;
  int m_stat = 0;
  int m_mask = 0;
  int exp_g[8] = '{22, 20, 15, 13, 12, 11, 10, 8};
  localparam logic [11:0] CTL = `PTBI_CTRL_OFFSET;
  localparam logic [11:0] STA = `PTBI_STATUS_OFFSET;
  localparam logic [11:0] MSK = `PTBI_MASK_OFFSET;
  ptbi_time_base ptbi_time_base_i (.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr),
    .wdata_i(wdata), .write_i(wr_s), .read_i(rd_s), .rdata_o(rdata), .op_mode_i(mode),
    .low_freq_base_select_i(lf_sel), .low_frequency_clock_i(lf_clk),
    .tick_interrupt_o(tick), .irq_o(irq));
  ptbi_intc_model ptbi_intc_model_i (.clock_i(clock_i), .reset_n_i(reset_n_i), .tick_i(tick),
    .count_o(count), .stamp_o(stamp), .cycle_o(cyc));
  initial forever #5 clock_i = ~clock_i;
  always begin
    repeat (3) @(posedge clock_i);
    lf_clk <= ~lf_clk;
  end
  always @(posedge clock_i) if (tick) m_stat = m_stat | 1;
  function automatic int rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_compared++;
    if (seen !== ex) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, ex, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input int d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d[7:0];
    wr_s <= 1'b1;
    @(posedge clock_i);
    wr_s <= 1'b0;
    if (a == CTL) m_ctrl = d & 15;
    if (a == STA) m_stat = m_stat & ~d;
    if (a == MSK) m_mask = d & 3;
  endtask
  task automatic rd(input logic [11:0] a);
    int e;
    e = (a == CTL) ? m_ctrl : (a == STA) ? m_stat : (a == MSK) ? m_mask : 0;
    @(posedge clock_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_i);
    rd_s <= 1'b0;
    #1;
    check("rdata", rdata, e);
    check("irq", irq, (m_stat & m_mask) != 0);
  endtask
  task automatic wait_tick(input int lim);
    n = count;
    for (int i = 0; i < lim && count == n; i++) @(posedge clock_i);
    #1;
    check("tick seen", count != n, 1);
  endtask
  task automatic quiet(input int cyc_n);
    n = count;
    repeat (cyc_n) @(posedge clock_i);
    check("no tick", count, n);
  endtask
  task automatic gear(input int c);
    int p;
    p = 1 << exp_g[c];
    wr(MSK, c != 7);
    wr(CTL, c);
    wr(CTL, 8 | c);
    t0 = cyc;
    wait_tick(p + 8);
    check("first gap", cyc - t0 <= p + 4, 1);
    t0 = stamp;
    wait_tick(p + 8);
    check("period", stamp - t0, p);
    rd(STA);
    wr(STA, 1);
    rd(STA);
    wr(CTL, c);
    $display("test gear code %0d done", c);
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clock_i);
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    rd(CTL);
    rd(STA);
    rd(MSK);
    $display("test reset done");
    repeat (4) begin
      v = rnd();
      wr(CTL, v & 8'hf7);
      rd(CTL);
    end
    wr(12'h040, 8'hff);
    rd(12'h040);
    $display("test registers done");
    for (int c = 7; c > 2; c--) gear(c);
    // no tick while disabled
    quiet(600);
    t0 = stamp;
    repeat ((rnd() & 63) + 1) @(posedge clock_i);
    mode <= ptbi_pkg::PTBI_MODE_IDLE;
    wr(CTL, 15);
    wait_tick(300);
    check("phase", (stamp - t0) % 256, 0);
    $display("test free run done");
    @(posedge clock_i);
    mode <= ptbi_pkg::PTBI_MODE_STOP;
    m_ctrl = 7;
    m_stat = m_stat | 2;
    quiet(600);
    rd(CTL);
    rd(STA);
    @(posedge clock_i);
    mode <= ptbi_pkg::PTBI_MODE_NORMAL;
    wr(STA, 3);
    $display("test stop done");
    lf_sel <= 1'b1;
    wr(CTL, 6);
    wr(CTL, 14);
    wait_tick(200);
    t0 = stamp;
    wait_tick(200);
    check("lf period", (stamp - t0 > 45) && (stamp - t0 < 51), 1);
    wr(CTL, 6);
    wr(CTL, 7);
    wr(CTL, 15);
    quiet(400);
    wr(CTL, 7);
    wr(CTL, 2);
    mode <= ptbi_pkg::PTBI_MODE_SLOW;
    wr(CTL, 10);
    quiet(400);
    mode <= ptbi_pkg::PTBI_MODE_SLEEP;
    quiet(100);
    wr(CTL, 2);
    mode <= ptbi_pkg::PTBI_MODE_NORMAL;
    $display("test low freq done");
    give_verdict();
  end
endmodule // tb_ptbi_time_base
`default_nettype wire
